/* include/ptc_consts.vh */
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH

// bus geometry
`define PTC_ADDR_W              8
`define PTC_DATA_W              32
`define PTC_RESP_OKAY           2'h0
`define PTC_RESP_DECERR         2'h3

// register byte offsets
`define PTC_OFF_TARGET_CONTROL  8'h90
`define PTC_OFF_RULE_ENABLE     8'h94
`define PTC_OFF_BURST_LENGTH    8'h98
`define PTC_OFF_STATUS          8'h9C

// target_control field positions
`define PTC_BIT_CACHE_DIS       19
`define PTC_BIT_OUT_NEVER_TO    18
`define PTC_BIT_IN_NEVER_TO     17
`define PTC_BIT_IO_PREFETCH     16
`define PTC_BIT_FORCE_RETRY     15
`define PTC_BIT_FORCE_ABORT     14
`define PTC_BIT_SINGLE_BURST    12

// rule_enable field positions
`define PTC_BIT_OUT_FIRST_EN    0
`define PTC_BIT_OUT_LATER_EN    1
`define PTC_BIT_IN_PHASE_EN     2

// burst length field
`define PTC_TBL_HI              7
`define PTC_TBL_LO              4
`define PTC_TBL_W               4

// reset values
`define PTC_RST_TARGET_CONTROL  32'h0000_0000
`define PTC_RST_RULE_ENABLE     3'h0
`define PTC_RST_BURST_LENGTH    8'h00

// latency limits in clocks
`define PTC_FIRST_PHASE_CLKS    5'h10
`define PTC_LATER_PHASE_CLKS    5'h08
`define PTC_TIMER_W             5

`endif

/* rtl/ptc_latency_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.vh"

module ptc_latency_timer #(
  parameter W = `PTC_TIMER_W
) (
  input  wire         clk_sys_i,
  input  wire         arst_n_i,
  input  wire         run_i,
  input  wire         clear_i,
  input  wire [W-1:0] limit_i,
  output reg          expire_o
);

  reg [W-1:0] count_r;
  reg         fired_r;

  // counts waiting clocks, fires once per phase
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count_r  <= {W{1'b0}};
      fired_r  <= 1'b0;
      expire_o <= 1'b0;
    end
    else
    begin
      expire_o <= 1'b0;
      if (clear_i)
      begin
        count_r <= {W{1'b0}};
        fired_r <= 1'b0;
      end
      else if (run_i && !fired_r)
      begin
        if (count_r == limit_i - {{(W-1){1'b0}}, 1'b1})
        begin
          expire_o <= 1'b1;
          fired_r  <= 1'b1;
        end
        else
        begin
          count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/ptc_axil_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.vh"

module ptc_axil_port (
  input  wire                     clk_sys_i,
  input  wire                     arst_n_i,
  input  wire                     awvalid_i,
  output reg                      awready_o,
  input  wire [`PTC_ADDR_W-1:0]   awaddr_i,
  input  wire                     wvalid_i,
  output reg                      wready_o,
  input  wire [`PTC_DATA_W-1:0]   wdata_i,
  input  wire [3:0]               wstrb_i,
  output reg                      bvalid_o,
  input  wire                     bready_i,
  output reg  [1:0]               bresp_o,
  input  wire                     arvalid_i,
  output reg                      arready_o,
  input  wire [`PTC_ADDR_W-1:0]   araddr_i,
  output reg                      rvalid_o,
  input  wire                     rready_i,
  output reg  [`PTC_DATA_W-1:0]   rdata_o,
  output reg  [1:0]               rresp_o,
  output reg                      wr_req_o,
  output reg  [`PTC_ADDR_W-1:0]   wr_addr_o,
  output reg  [`PTC_DATA_W-1:0]   wr_data_o,
  output reg  [3:0]               wr_strb_o,
  input  wire                     wr_err_i,
  output wire [`PTC_ADDR_W-1:0]   rd_addr_o,
  input  wire [`PTC_DATA_W-1:0]   rd_data_i,
  input  wire                     rd_err_i
);

  reg aw_held_r;
  reg w_held_r;

  assign rd_addr_o = araddr_i;

  // address and data taken in either order, response after both
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_o  <= 1'b0;
      bresp_o   <= `PTC_RESP_OKAY;
      wr_req_o  <= 1'b0;
      wr_addr_o <= {`PTC_ADDR_W{1'b0}};
      wr_data_o <= {`PTC_DATA_W{1'b0}};
      wr_strb_o <= 4'h0;
    end
    else
    begin
      wr_req_o <= 1'b0;
      if (awvalid_i && awready_o)
      begin
        wr_addr_o <= awaddr_i;
        aw_held_r <= 1'b1;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o)
      begin
        wr_data_o <= wdata_i;
        wr_strb_o <= wstrb_i;
        w_held_r  <= 1'b1;
        wready_o  <= 1'b0;
      end
      if (aw_held_r && w_held_r && !bvalid_o && !wr_req_o)
      begin
        wr_req_o <= 1'b1;
      end
      if (wr_req_o)
      begin
        bvalid_o  <= 1'b1;
        bresp_o   <= wr_err_i ? `PTC_RESP_DECERR : `PTC_RESP_OKAY;
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end
      if (bvalid_o && bready_i)
      begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= {`PTC_DATA_W{1'b0}};
      rresp_o   <= `PTC_RESP_OKAY;
    end
    else
    begin
      if (arvalid_i && arready_o)
      begin
        arready_o <= 1'b0;
        rvalid_o  <= 1'b1;
        rdata_o   <= rd_err_i ? {`PTC_DATA_W{1'b0}} : rd_data_i;
        rresp_o   <= rd_err_i ? `PTC_RESP_DECERR : `PTC_RESP_OKAY;
      end
      else if (rvalid_o && rready_i)
      begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/ptc_target_ctrl.v */
// Function
// - outbound never-timeout suppresses first-phase 16-clock timeout when that rule is enabled.
// - outbound never-timeout suppresses later-phase 8-clock timeout when that rule is enabled.
// - suppressed outbound timeouts cause neither retry nor disconnect.
// - without never-timeout, enabled outbound timeout expiry gives retry or disconnect.
// - inbound never-timeout ignores the 8-clock limit; no disconnect on it.
// - without inbound never-timeout, enabled 8-clock expiry disconnects the initiator.
// - I/O prefetch bit makes I/O commands behave as memory commands.
// - force-retry ends current transaction: retry before data, disconnect after.
// - force-retry clears itself once the forced termination completes.
// - force-abort ends current transaction with target-abort, then clears itself.
// - writing 0 to force bits changes nothing.
// - single-burst: one local-bus read per transaction, sized by burst length.
// - control bits reset to 0.
// - caching disabled: leftover outbound data discarded when transaction completes.
// - single-burst off: keep streaming while room for next burst and transaction runs.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.vh"

module ptc_target_ctrl (
  input  wire                    clk_sys_i,
  input  wire                    arst_n_i,
  input  wire                    s_axil_awvalid_i,
  output wire                    s_axil_awready_o,
  input  wire [`PTC_ADDR_W-1:0]  s_axil_awaddr_i,
  input  wire                    s_axil_wvalid_i,
  output wire                    s_axil_wready_o,
  input  wire [`PTC_DATA_W-1:0]  s_axil_wdata_i,
  input  wire [3:0]              s_axil_wstrb_i,
  output wire                    s_axil_bvalid_o,
  input  wire                    s_axil_bready_i,
  output wire [1:0]              s_axil_bresp_o,
  input  wire                    s_axil_arvalid_i,
  output wire                    s_axil_arready_o,
  input  wire [`PTC_ADDR_W-1:0]  s_axil_araddr_i,
  output wire                    s_axil_rvalid_o,
  input  wire                    s_axil_rready_i,
  output wire [`PTC_DATA_W-1:0]  s_axil_rdata_o,
  output wire [1:0]              s_axil_rresp_o,
  input  wire                    txn_start_i,
  input  wire                    txn_end_i,
  input  wire                    txn_read_i,
  input  wire                    txn_io_i,
  input  wire                    data_wait_i,
  input  wire                    data_xfer_i,
  input  wire                    outbound_fifo_room_i,
  input  wire                    lb_rd_done_i,
  output reg                     term_retry_o,
  output reg                     term_disconnect_o,
  output reg                     term_abort_o,
  output reg                     prefetchable_o,
  output reg                     outbound_fifo_discard_o,
  output reg                     lb_rd_req_o,
  output reg  [`PTC_TBL_W-1:0]   lb_burst_len_o
);

  // byte-lane merge for register writes
  function [`PTC_DATA_W-1:0] merge_strb;
    input [`PTC_DATA_W-1:0] old_v;
    input [`PTC_DATA_W-1:0] new_v;
    input [3:0]             strb;
    integer i;
    begin
      merge_strb = old_v;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (strb[i])
        begin
          merge_strb[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  function addr_known;
    input [`PTC_ADDR_W-1:0] a;
    begin
      addr_known = (a == `PTC_OFF_TARGET_CONTROL) || (a == `PTC_OFF_RULE_ENABLE) ||
                   (a == `PTC_OFF_BURST_LENGTH) || (a == `PTC_OFF_STATUS);
    end
  endfunction

  wire                    wr_req;
  wire [`PTC_ADDR_W-1:0]  wr_addr;
  wire [`PTC_DATA_W-1:0]  wr_data;
  wire [3:0]              wr_strb;
  wire [`PTC_ADDR_W-1:0]  rd_addr;
  reg  [`PTC_DATA_W-1:0]  rd_data;
  wire                    timer_expire;

  reg                     cache_dis_r;
  reg                     out_never_to_r;
  reg                     in_never_to_r;
  reg                     io_prefetch_r;
  reg                     force_retry_r;
  reg                     force_abort_r;
  reg                     single_burst_r;
  reg  [2:0]              rule_en_r;
  reg  [7:0]              burst_len_r;

  reg                     txn_active_r;
  reg                     first_phase_r;
  reg                     data_moved_r;
  reg                     term_sent_r;
  reg                     forced_r;
  reg                     burst_issued_r;
  reg                     rd_pending_r;
  reg                     txn_was_read_r;

  reg                     retry_nxt;
  reg                     disc_nxt;
  reg                     abort_nxt;
  reg                     forced_nxt;
  reg  [`PTC_TIMER_W-1:0] limit_nxt;
  reg                     to_allowed;

  wire wr_tc    = wr_req && (wr_addr == `PTC_OFF_TARGET_CONTROL);
  wire wr_rule  = wr_req && (wr_addr == `PTC_OFF_RULE_ENABLE);
  wire wr_burst = wr_req && (wr_addr == `PTC_OFF_BURST_LENGTH);
  wire [`PTC_DATA_W-1:0] tc_cur = {12'h000, cache_dis_r, out_never_to_r, in_never_to_r,
                                   io_prefetch_r, force_retry_r, force_abort_r, 1'b0,
                                   single_burst_r, 12'h000};
  wire [`PTC_DATA_W-1:0] tc_new = merge_strb(tc_cur, wr_data, wr_strb);
  wire [`PTC_DATA_W-1:0] ru_new = merge_strb({29'h0, rule_en_r}, wr_data, wr_strb);
  wire [`PTC_DATA_W-1:0] bl_new = merge_strb({24'h0, burst_len_r}, wr_data, wr_strb);
  wire set_retry = wr_tc && tc_new[`PTC_BIT_FORCE_RETRY];
  wire set_abort = wr_tc && tc_new[`PTC_BIT_FORCE_ABORT];
  wire force_done = txn_end_i && forced_r;

  ptc_axil_port u_port (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .awvalid_i (s_axil_awvalid_i),
    .awready_o (s_axil_awready_o),
    .awaddr_i  (s_axil_awaddr_i),
    .wvalid_i  (s_axil_wvalid_i),
    .wready_o  (s_axil_wready_o),
    .wdata_i   (s_axil_wdata_i),
    .wstrb_i   (s_axil_wstrb_i),
    .bvalid_o  (s_axil_bvalid_o),
    .bready_i  (s_axil_bready_i),
    .bresp_o   (s_axil_bresp_o),
    .arvalid_i (s_axil_arvalid_i),
    .arready_o (s_axil_arready_o),
    .araddr_i  (s_axil_araddr_i),
    .rvalid_o  (s_axil_rvalid_o),
    .rready_i  (s_axil_rready_i),
    .rdata_o   (s_axil_rdata_o),
    .rresp_o   (s_axil_rresp_o),
    .wr_req_o  (wr_req),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_err_i  (!addr_known(wr_addr)),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_err_i  (!addr_known(rd_addr))
  );

  // register file
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cache_dis_r    <= 1'b0;
      out_never_to_r <= 1'b0;
      in_never_to_r  <= 1'b0;
      io_prefetch_r  <= 1'b0;
      force_retry_r  <= 1'b0;
      force_abort_r  <= 1'b0;
      single_burst_r <= 1'b0;
      rule_en_r      <= `PTC_RST_RULE_ENABLE;
      burst_len_r    <= `PTC_RST_BURST_LENGTH;
    end
    else
    begin
      if (wr_tc)
      begin
        cache_dis_r    <= tc_new[`PTC_BIT_CACHE_DIS];
        out_never_to_r <= tc_new[`PTC_BIT_OUT_NEVER_TO];
        in_never_to_r  <= tc_new[`PTC_BIT_IN_NEVER_TO];
        io_prefetch_r  <= tc_new[`PTC_BIT_IO_PREFETCH];
        single_burst_r <= tc_new[`PTC_BIT_SINGLE_BURST];
      end
      // self clear at termination; a new write of 1 wins
      if (set_retry)
      begin
        force_retry_r <= 1'b1;
      end
      else if (force_done)
      begin
        force_retry_r <= 1'b0;
      end
      if (set_abort)
      begin
        force_abort_r <= 1'b1;
      end
      else if (force_done)
      begin
        force_abort_r <= 1'b0;
      end
      if (wr_rule)
      begin
        rule_en_r <= ru_new[2:0];
      end
      if (wr_burst)
      begin
        burst_len_r <= bl_new[7:0];
      end
    end
  end

  // read mux
  always @*
  begin
    rd_data = {`PTC_DATA_W{1'b0}};
    case (rd_addr)
      `PTC_OFF_TARGET_CONTROL: rd_data = tc_cur;
      `PTC_OFF_RULE_ENABLE:    rd_data = {29'h0, rule_en_r};
      `PTC_OFF_BURST_LENGTH:   rd_data = {24'h0, burst_len_r};
      `PTC_OFF_STATUS:         rd_data = {25'h0, txn_was_read_r, rd_pending_r, burst_issued_r,
                                          term_sent_r, data_moved_r, first_phase_r, txn_active_r};
      default:                 rd_data = {`PTC_DATA_W{1'b0}};
    endcase
  end

  // wait-clock timer, limit depends on phase and direction
  always @*
  begin
    limit_nxt  = `PTC_LATER_PHASE_CLKS;
    to_allowed = 1'b0;
    if (txn_read_i)
    begin
      if (first_phase_r)
      begin
        limit_nxt  = `PTC_FIRST_PHASE_CLKS;
        to_allowed = rule_en_r[`PTC_BIT_OUT_FIRST_EN] && !out_never_to_r;
      end
      else
      begin
        to_allowed = rule_en_r[`PTC_BIT_OUT_LATER_EN] && !out_never_to_r;
      end
    end
    else
    begin
      to_allowed = rule_en_r[`PTC_BIT_IN_PHASE_EN] && !in_never_to_r;
    end
  end

  ptc_latency_timer #(
    .W (`PTC_TIMER_W)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .run_i     (txn_active_r && data_wait_i),
    .clear_i   (data_xfer_i || txn_start_i || txn_end_i),
    .limit_i   (limit_nxt),
    .expire_o  (timer_expire)
  );

  // termination choice; abort outranks retry
  always @*
  begin
    retry_nxt  = 1'b0;
    disc_nxt   = 1'b0;
    abort_nxt  = 1'b0;
    forced_nxt = 1'b0;
    if (txn_active_r && !term_sent_r && !txn_end_i)
    begin
      if (force_abort_r)
      begin
        abort_nxt  = 1'b1;
        forced_nxt = 1'b1;
      end
      else if (force_retry_r)
      begin
        retry_nxt  = !(data_moved_r || data_xfer_i);
        disc_nxt   = data_moved_r || data_xfer_i;
        forced_nxt = 1'b1;
      end
      else if (timer_expire && to_allowed)
      begin
        retry_nxt = txn_read_i && !(data_moved_r || data_xfer_i);
        disc_nxt  = !(txn_read_i && !(data_moved_r || data_xfer_i));
      end
    end
  end

  // transaction tracking and termination outputs
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      txn_active_r      <= 1'b0;
      first_phase_r     <= 1'b0;
      data_moved_r      <= 1'b0;
      term_sent_r       <= 1'b0;
      forced_r          <= 1'b0;
      txn_was_read_r    <= 1'b0;
      term_retry_o      <= 1'b0;
      term_disconnect_o <= 1'b0;
      term_abort_o      <= 1'b0;
      prefetchable_o    <= 1'b0;
      outbound_fifo_discard_o   <= 1'b0;
    end
    else
    begin
      term_retry_o      <= retry_nxt;
      term_disconnect_o <= disc_nxt;
      term_abort_o      <= abort_nxt;
      outbound_fifo_discard_o   <= 1'b0;
      if (retry_nxt || disc_nxt || abort_nxt)
      begin
        term_sent_r <= 1'b1;
      end
      if (forced_nxt)
      begin
        forced_r <= 1'b1;
      end
      if (data_xfer_i)
      begin
        data_moved_r  <= 1'b1;
        first_phase_r <= 1'b0;
      end
      if (txn_start_i)
      begin
        txn_active_r   <= 1'b1;
        first_phase_r  <= 1'b1;
        data_moved_r   <= 1'b0;
        term_sent_r    <= 1'b0;
        forced_r       <= 1'b0;
        txn_was_read_r <= txn_read_i;
        prefetchable_o <= !txn_io_i || io_prefetch_r;
      end
      else if (txn_end_i)
      begin
        txn_active_r    <= 1'b0;
        first_phase_r   <= 1'b0;
        term_sent_r     <= 1'b0;
        forced_r        <= 1'b0;
        outbound_fifo_discard_o <= cache_dis_r && txn_was_read_r;
      end
    end
  end

  // local-bus read requests for the outbound fifo
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lb_rd_req_o    <= 1'b0;
      lb_burst_len_o <= {`PTC_TBL_W{1'b0}};
      burst_issued_r <= 1'b0;
      rd_pending_r   <= 1'b0;
    end
    else
    begin
      lb_rd_req_o <= 1'b0;
      if (lb_rd_done_i)
      begin
        rd_pending_r <= 1'b0;
      end
      if (txn_start_i)
      begin
        burst_issued_r <= 1'b0;
      end
      else if (txn_active_r && txn_was_read_r && !rd_pending_r && !lb_rd_req_o && !txn_end_i)
      begin
        if (single_burst_r)
        begin
          if (!burst_issued_r)
          begin
            lb_rd_req_o    <= 1'b1;
            lb_burst_len_o <= burst_len_r[`PTC_TBL_HI:`PTC_TBL_LO];
            burst_issued_r <= 1'b1;
            rd_pending_r   <= 1'b1;
          end
        end
        else if (outbound_fifo_room_i)
        begin
          lb_rd_req_o    <= 1'b1;
          lb_burst_len_o <= burst_len_r[`PTC_TBL_HI:`PTC_TBL_LO];
          burst_issued_r <= 1'b1;
          rd_pending_r   <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* test/ptc_target_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ptc_target_ctrl_checker (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic txn_start_i,
  input wire logic txn_end_i,
  input wire logic txn_io_i,
  input wire logic data_xfer_i,
  input wire logic term_retry_o,
  input wire logic term_disconnect_o,
  input wire logic term_abort_o,
  input wire logic prefetchable_o,
  input wire logic outbound_fifo_discard_o,
  input wire logic lb_rd_req_o
);
  logic [2:0] hlp_r;
  wire        trm = term_retry_o | term_disconnect_o | term_abort_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // active, data moved, term sent
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      hlp_r <= 3'h0;
    else if (txn_start_i)
      hlp_r <= 3'h1;
    else
      hlp_r <= {hlp_r[2] | trm, hlp_r[1] | data_xfer_i, hlp_r[0] & ~txn_end_i};
  property p_one;
    trm |-> $onehot({term_retry_o, term_disconnect_o, term_abort_o});
  endproperty
  a_one: assert property (p_one) else $error("terms overlap");
  property p_once;
    trm |-> hlp_r[0] && !hlp_r[2];
  endproperty
  a_once: assert property (p_once) else $error("term outside txn or twice");
  property p_retry;
    term_retry_o |-> !hlp_r[1];
  endproperty
  a_retry: assert property (p_retry) else $error("retry after data");
  property p_end;
    txn_end_i |-> !trm;
  endproperty
  a_end: assert property (p_end) else $error("term at txn end");
  property p_disc;
    outbound_fifo_discard_o |-> $past(txn_end_i);
  endproperty
  a_disc: assert property (p_disc) else $error("discard without end");
  property p_mem;
    txn_start_i && !txn_io_i |=> prefetchable_o;
  endproperty
  a_mem: assert property (p_mem) else $error("memory cmd not prefetchable");
  property p_hold;
    !txn_start_i |=> $stable(prefetchable_o);
  endproperty
  a_hold: assert property (p_hold) else $error("prefetchable moved mid txn");
  property p_lb;
    lb_rd_req_o |-> hlp_r[0];
  endproperty
  a_lb: assert property (p_lb) else $error("read request while idle");
endmodule
bind ptc_target_ctrl ptc_target_ctrl_checker u_chk (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .txn_start_i(txn_start_i), .txn_end_i(txn_end_i),
  .txn_io_i(txn_io_i), .data_xfer_i(data_xfer_i), .term_retry_o(term_retry_o),
  .term_disconnect_o(term_disconnect_o), .term_abort_o(term_abort_o),
  .prefetchable_o(prefetchable_o), .outbound_fifo_discard_o(outbound_fifo_discard_o), .lb_rd_req_o(lb_rd_req_o)
);
`default_nettype wire

/* test/ptc_initiator_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ptc_initiator_model (
  input  wire logic clk_sys_i,
  input  wire logic term_retry_i,
  input  wire logic term_disconnect_i,
  input  wire logic term_abort_i,
  output var  logic txn_start_o,
  output var  logic txn_end_o,
  output var  logic txn_read_o,
  output var  logic txn_io_o,
  output var  logic data_wait_o,
  output var  logic data_xfer_o
);
  logic [3:0] n_rt = 4'h0;
  logic [3:0] n_dc = 4'h0;
  logic [3:0] n_ab = 4'h0;
  initial
    {txn_start_o, txn_end_o, txn_read_o, txn_io_o, data_wait_o, data_xfer_o} = 6'h00;
  // terminations seen in the running transaction
  always @(posedge clk_sys_i)
  begin
    if (term_retry_i)
      n_rt <= n_rt + 4'h1;
    if (term_disconnect_i)
      n_dc <= n_dc + 4'h1;
    if (term_abort_i)
      n_ab <= n_ab + 4'h1;
  end
  function automatic logic ended();
    return (n_rt | n_dc | n_ab) != 4'h0;
  endfunction
  // a terminated initiator stops waiting and moves no more data
  task automatic run(input logic rd, input logic io, input int nph, input int nw);
    {n_rt, n_dc, n_ab} = 12'h000;
    txn_read_o <= rd;
    txn_io_o <= io;
    txn_start_o <= 1'b1;
    @(posedge clk_sys_i);
    txn_start_o <= 1'b0;
    for (int p = 0; p < nph && !ended(); p++)
    begin
      data_wait_o <= 1'b1;
      for (int w = 0; w < nw && !ended(); w++)
        @(posedge clk_sys_i);
      data_wait_o <= 1'b0;
      data_xfer_o <= !ended();
      @(posedge clk_sys_i);
      data_xfer_o <= 1'b0;
    end
    txn_end_o <= 1'b1;
    @(posedge clk_sys_i);
    txn_end_o <= 1'b0;
    // released lines do not keep their level
    txn_read_o <= ~rd;
    txn_io_o <= ~io;
    repeat (2) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

/* test/ptc_target_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ptc_target_ctrl_tb;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, room = 1'b0, lbd = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  wire         awr, wrd, bv, arr, rv, ts, te, trd, tio, dw, dx, rt, dc, ab, pf, dis, lrq;
  wire  [1:0]  br, rr;
  wire  [31:0] rd;
  wire  [3:0]  bl;
  int          error_cnt = 0, n_checks = 0, nreq = 0, ndis = 0;
  ptc_target_ctrl uut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .s_axil_awvalid_i(awv), .s_axil_awready_o(awr),
    .s_axil_awaddr_i(awa), .s_axil_wvalid_i(wv), .s_axil_wready_o(wrd), .s_axil_wdata_i(wd),
    .s_axil_wstrb_i(4'hF), .s_axil_bvalid_o(bv), .s_axil_bready_i(bry), .s_axil_bresp_o(br),
    .s_axil_arvalid_i(arv), .s_axil_arready_o(arr), .s_axil_araddr_i(ara), .s_axil_rvalid_o(rv),
    .s_axil_rready_i(rry), .s_axil_rdata_o(rd), .s_axil_rresp_o(rr), .txn_start_i(ts),
    .txn_end_i(te), .txn_read_i(trd), .txn_io_i(tio), .data_wait_i(dw), .data_xfer_i(dx),
    .outbound_fifo_room_i(room), .lb_rd_done_i(lbd), .term_retry_o(rt), .term_disconnect_o(dc),
    .term_abort_o(ab), .prefetchable_o(pf), .outbound_fifo_discard_o(dis), .lb_rd_req_o(lrq),
    .lb_burst_len_o(bl)
  );
  ptc_initiator_model u_init (
    .clk_sys_i(clk_sys_i), .term_retry_i(rt), .term_disconnect_i(dc), .term_abort_i(ab),
    .txn_start_o(ts), .txn_end_o(te), .txn_read_o(trd), .txn_io_o(tio), .data_wait_o(dw),
    .data_xfer_o(dx)
  );
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tmo;
    error_cnt++;
    give_verdict;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // local-bus read answers one cycle after the request
  always @(posedge clk_sys_i)
  begin
    lbd <= lrq;
    nreq += (lrq === 1'b1);
    ndis += (dis === 1'b1);
    if (lrq === 1'b1)
      chk(32'(bl), 32'h3);
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_sys_i);
      if (bv === 1'b1 && !awv && !wv)
        break;
      awv <= awv & ~awr;
      wv <= wv & ~wrd;
    end
    if (n == 40)
      tmo;
    r = br;
    bry <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys_i);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_sys_i);
      if (rv === 1'b1 && !arv)
        break;
      arv <= arv & ~arr;
    end
    if (n == 40)
      tmo;
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  // one transaction; optional control write fd cycles after start
  task automatic txn_chk(input logic [31:0] ctl, input logic [2:0] en, input logic rdn, input int nph,
                         input int nw, input logic [31:0] fv, input int fd, input logic [11:0] ex);
    wreg(8'h94, {29'h0, en});
    wreg(8'h90, ctl);
    fork
      u_init.run(rdn, 1'b0, nph, nw);
      if (fd > 0)
      begin
        repeat (fd) @(posedge clk_sys_i);
        wreg(8'h90, fv);
      end
    join
    chk(32'({u_init.n_ab, u_init.n_dc, u_init.n_rt}), 32'(ex));
    rdchk(8'h90, (fd > 0 ? fv : ctl) & 32'h000F_1000, 2'h0);
  endtask
  task automatic s_regs;
    logic [1:0] r;
    rdchk(8'h90, 32'h0, 2'h0);
    rdchk(8'h94, 32'h0, 2'h0);
    wreg(8'h90, 32'h8000);
    axw(8'h90, 32'hFFFF_3FFF, r);
    rdchk(8'h90, 32'h000F_9000, 2'h0);
    u_init.run(1'b0, 1'b0, 1, 4);
    chk(32'(u_init.n_rt), 32'h1);
    axw(8'h40, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'h3);
    rdchk(8'h90, 32'h000F_1000, 2'h0);
    rdchk(8'h40, 32'h0, 2'h3);
  endtask
  task automatic s_outbound;
    txn_chk(32'h1000, 3'h1, 1'b1, 1, 20, 32'h0, 0, 12'h001);
    txn_chk(32'h1000, 3'h1, 1'b1, 1, 14, 32'h0, 0, 12'h000);
    txn_chk(32'h41000, 3'h1, 1'b1, 1, 20, 32'h0, 0, 12'h000);
    txn_chk(32'h1000, 3'h2, 1'b1, 2, 12, 32'h0, 0, 12'h010);
    txn_chk(32'h41000, 3'h2, 1'b1, 2, 12, 32'h0, 0, 12'h000);
  endtask
  task automatic s_inbound;
    txn_chk(32'h1000, 3'h4, 1'b0, 2, 12, 32'h0, 0, 12'h010);
    txn_chk(32'h21000, 3'h4, 1'b0, 2, 12, 32'h0, 0, 12'h000);
  endtask
  task automatic s_force;
    txn_chk(32'h1000, 3'h0, 1'b1, 1, 30, 32'h9000, 4, 12'h001);
    txn_chk(32'h1000, 3'h0, 1'b1, 4, 6, 32'h9000, 12, 12'h010);
    txn_chk(32'h1000, 3'h0, 1'b0, 1, 30, 32'hD000, 4, 12'h100);
    txn_chk(32'h1000, 3'h0, 1'b1, 2, 10, 32'h1000, 4, 12'h000);
  endtask
  task automatic s_prefetch;
    wreg(8'h94, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wreg(8'h90, i[0] ? 32'h11000 : 32'h1000);
      fork
        u_init.run(1'b1, i < 2, 1, 4);
        begin
          repeat (2) @(posedge clk_sys_i);
          chk(32'(pf), 32'(i != 0));
        end
      join
    end
  endtask
  task automatic s_burst;
    nreq = 0;
    ndis = 0;
    txn_chk(32'h1000, 3'h0, 1'b1, 4, 3, 32'h0, 0, 12'h000);
    chk(32'(nreq), 32'h1);
    chk(32'(ndis), 32'h0);
    nreq = 0;
    txn_chk(32'h80000, 3'h0, 1'b1, 4, 3, 32'h0, 0, 12'h000);
    chk(32'(nreq > 1), 32'h1);
    chk(32'(ndis), 32'h1);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    room <= 1'b1;
    s_regs;
    wreg(8'h98, 32'h30);
    s_outbound;
    s_inbound;
    s_force;
    s_prefetch;
    s_burst;
    give_verdict;
  end
endmodule
`default_nettype wire
